// ==== design/psb_pkg.sv ====
package psb_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int LANES = 4;
  localparam int LANE_DATA_W = 8;
  localparam int LANE_W = LANE_DATA_W + 1;
  localparam int BURST_W = 2;
  localparam int ADDR_W_DEF = 19;
  localparam int SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // Reset and constant values
  // ----------------------------------------------------------------
  localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
  localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
  localparam logic [LANES-1:0] MASK_NONE = 4'h0;
  localparam logic [LANES-1:0] MASK_ALL = 4'hF;

  // Synchronous control pins sampled on the clock edge
  typedef struct packed {
    logic chipSelectPrimary_n;
    logic chipSelectExpandHi;
    logic chipSelectExpand_n;
    logic procAddrStrobe_n;
    logic ctrlAddrStrobe_n;
    logic burstAdvance_n;
    logic globalWrite_n;
    logic byteWriteEnable_n;
    logic [LANES-1:0] byteSelect_n;
  } psb_ctrl_pins_t;

  // One word on the data lines: data bytes plus one parity line per lane
  typedef struct packed {
    logic [LANES-1:0] parityLines;
    logic [LANES*LANE_DATA_W-1:0] data;
  } psb_word_t;

  // Kind of cycle decoded at an edge
  typedef enum logic [1:0] {
    PSB_IDLE,
    PSB_READ,
    PSB_WRITE
  } psb_cycle_t;

  // Lane slice of a word: data byte with its parity bit on top
  function automatic logic [LANE_W-1:0] psb_lane(input psb_word_t w, input int lane);
    psb_lane = {w.parityLines[lane], w.data[lane*LANE_DATA_W +: LANE_DATA_W]};
  endfunction : psb_lane

  // Lanes to write from the write controls
  function automatic logic [LANES-1:0] psb_write_mask(input psb_ctrl_pins_t p);
    if (!p.globalWrite_n) begin
      psb_write_mask = MASK_ALL;
    end else if (!p.byteWriteEnable_n) begin
      psb_write_mask = ~p.byteSelect_n;
    end else begin
      psb_write_mask = MASK_NONE;
    end
  endfunction : psb_write_mask

endpackage : psb_pkg

// ==== design/psb_pin_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module psb_pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  import psb_pkg::*;

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;
  logic [WIDTH-1:0] stage3_r;
  logic [WIDTH-1:0] level_r;
  logic [WIDTH-1:0] level_nxt;

  // Accept a new level only when the two later stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      level_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i] : level_r[i];
    end
  end

  // Three-stage shift and filtered level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
      stage3_r <= RESET_VAL;
      level_r <= RESET_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      level_r <= level_nxt;
    end
  end

  assign pinOut = level_r;
endmodule : psb_pin_sync
`default_nettype wire

// ==== design/psb_burst_counter.sv ====
`timescale 1ns/1ps
`default_nettype none
module psb_burst_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [psb_pkg::BURST_W-1:0] loadValue,
  input wire logic advance,
  input wire logic interleaved,
  output logic [psb_pkg::BURST_W-1:0] count
);
  import psb_pkg::*;

  logic [BURST_W-1:0] base_r;
  logic [BURST_W-1:0] base_nxt;
  logic [BURST_W-1:0] step_r;
  logic [BURST_W-1:0] step_nxt;

  // Load restarts the sequence; advance steps it and wraps in four
  always_comb begin
    base_nxt = base_r;
    step_nxt = step_r;
    if (load) begin
      base_nxt = loadValue;
      step_nxt = BURST_ZERO;
    end else if (advance) begin
      step_nxt = step_r + BURST_STEP;
    end
  end

  // Counter state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      base_r <= BURST_ZERO;
      step_r <= BURST_ZERO;
    end else begin
      base_r <= base_nxt;
      step_r <= step_nxt;
    end
  end

  // Burst address of the access taken at this edge, load or advance included
  // Linear adds the step, interleaved flips bits by it
  assign count = interleaved ? (base_nxt ^ step_nxt) : (base_nxt + step_nxt);
endmodule : psb_burst_counter
`default_nettype wire

// ==== design/psb_sram_ctrl.sv ====
`timescale 1ns/1ps
`default_nettype none
module psb_sram_ctrl #(
  parameter int ADDR_W = psb_pkg::ADDR_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire psb_pkg::psb_ctrl_pins_t ctrlPins,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burstOrderInterleave,
  input wire psb_pkg::psb_word_t dqIn,
  output psb_pkg::psb_word_t dqOut,
  output logic dqOutEnable_n,
  output logic sleepActive,
  output logic deviceSelected
);
  import psb_pkg::*;

  localparam int DEPTH = 1 << ADDR_W;
  localparam int UPPER_W = ADDR_W - BURST_W;

  // ----------------------------------------------------------------
  // Asynchronous pins brought into the clock domain
  // ----------------------------------------------------------------
  logic oeSync_n;
  logic sleepSync;

  // Output enable and sleep both pass the three-stage filter
  psb_pin_sync #(
    .WIDTH(2),
    .RESET_VAL(2'h2)
  ) u_pin_sync (
    .clk(clk),
    .rst_n(rst_n),
    .pinIn({output_enable_n, sleep_request}),
    .pinOut({oeSync_n, sleepSync})
  );

  // ----------------------------------------------------------------
  // Strobe and select decode
  // ----------------------------------------------------------------
  logic allSelected;
  logic procLoad;
  logic ctrlLoad;
  logic anyLoad;
  logic [LANES-1:0] sampledMask;

  // Chip selects count only when an address is loaded
  always_comb begin
    allSelected = !ctrlPins.chipSelectPrimary_n
      && ctrlPins.chipSelectExpandHi
      && !ctrlPins.chipSelectExpand_n;
    procLoad = !sleepSync && !ctrlPins.procAddrStrobe_n
      && !ctrlPins.chipSelectPrimary_n;
    ctrlLoad = !sleepSync && !procLoad && !ctrlPins.ctrlAddrStrobe_n;
    anyLoad = procLoad || ctrlLoad;
    sampledMask = psb_write_mask(ctrlPins);
  end

  // ----------------------------------------------------------------
  // Burst order strap and burst counter
  // ----------------------------------------------------------------
  logic interleave_r;
  logic interleave_nxt;
  logic [BURST_W-1:0] burstCount;
  logic selected_r;
  logic selected_nxt;
  logic advanceNow;

  // Strap is caught while reset is held and frozen afterwards
  always_comb begin
    interleave_nxt = rst_n ? interleave_r : burstOrderInterleave;
  end

  // Strap register
  always_ff @(posedge clk) begin
    interleave_r <= interleave_nxt;
  end

  // Advance counts only in a continuing selected burst
  assign advanceNow = selected_r && !anyLoad && !sleepSync
    && !ctrlPins.burstAdvance_n;

  psb_burst_counter u_burst (
    .clk(clk),
    .rst_n(rst_n),
    .load(anyLoad && allSelected),
    .loadValue(addrIn[BURST_W-1:0]),
    .advance(advanceNow),
    .interleaved(interleave_r),
    .count(burstCount)
  );

  // ----------------------------------------------------------------
  // Access sequencing
  // ----------------------------------------------------------------
  logic [UPPER_W-1:0] upper_r;
  logic [UPPER_W-1:0] upper_nxt;
  logic firstMask_r;
  logic firstMask_nxt;
  logic wrPend_r;
  logic wrPend_nxt;
  logic [ADDR_W-1:0] wrAddr_r;
  logic [ADDR_W-1:0] wrAddr_nxt;
  logic [LANES-1:0] wrMask_r;
  logic [LANES-1:0] wrMask_nxt;
  psb_word_t wrData_r;
  psb_word_t wrData_nxt;
  logic rdPend_r;
  logic rdPend_nxt;
  logic [ADDR_W-1:0] rdAddr_r;
  logic [ADDR_W-1:0] rdAddr_nxt;
  logic drive_r;
  logic drive_nxt;
  psb_cycle_t cycle;
  logic [ADDR_W-1:0] accessAddr;
  logic [LANES-1:0] accessMask;

  // Decide the kind of cycle and its address at this edge
  always_comb begin
    cycle = PSB_IDLE;
    accessAddr = {upper_r, burstCount};
    accessMask = MASK_NONE;
    selected_nxt = selected_r;
    upper_nxt = upper_r;
    firstMask_nxt = 1'b0;
    if (sleepSync) begin
      selected_nxt = 1'b0;
    end else if (anyLoad) begin
      selected_nxt = allSelected;
      if (allSelected) begin
        upper_nxt = addrIn[ADDR_W-1:BURST_W];
        accessAddr = addrIn;
        firstMask_nxt = !selected_r;
        if (ctrlLoad && (sampledMask != MASK_NONE)) begin
          cycle = PSB_WRITE;
          accessMask = sampledMask;
        end else begin
          cycle = PSB_READ;
        end
      end
    end else if (selected_r) begin
      // Counter output already holds this edge's advance in either order
      // Adding one here would break the interleaved sequence
      if (sampledMask != MASK_NONE) begin
        cycle = PSB_WRITE;
        accessMask = sampledMask;
      end else begin
        cycle = PSB_READ;
      end
    end
  end

  // Register the write and read pipelines
  always_comb begin
    wrPend_nxt = (cycle == PSB_WRITE);
    wrAddr_nxt = wrAddr_r;
    wrMask_nxt = accessMask;
    wrData_nxt = wrData_r;
    rdPend_nxt = (cycle == PSB_READ);
    rdAddr_nxt = rdAddr_r;
    drive_nxt = rdPend_r && (cycle != PSB_WRITE) && !sleepSync && selected_nxt;
    if (cycle == PSB_WRITE) begin
      wrAddr_nxt = accessAddr;
      wrData_nxt = dqIn;
    end
    if (cycle == PSB_READ) begin
      rdAddr_nxt = accessAddr;
    end
  end

  // Sequencing state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      selected_r <= 1'b0;
      upper_r <= '0;
      firstMask_r <= 1'b0;
      wrPend_r <= 1'b0;
      wrAddr_r <= '0;
      wrMask_r <= MASK_NONE;
      wrData_r <= '0;
      rdPend_r <= 1'b0;
      rdAddr_r <= '0;
      drive_r <= 1'b0;
    end else begin
      selected_r <= selected_nxt;
      upper_r <= upper_nxt;
      firstMask_r <= firstMask_nxt;
      wrPend_r <= wrPend_nxt;
      wrAddr_r <= wrAddr_nxt;
      wrMask_r <= wrMask_nxt;
      wrData_r <= wrData_nxt;
      rdPend_r <= rdPend_nxt;
      rdAddr_r <= rdAddr_nxt;
      drive_r <= drive_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Storage array, one memory per byte lane
  // ----------------------------------------------------------------
  psb_word_t outWord_r;
  psb_word_t outWord_nxt;

  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LANE_W-1:0] laneMem [DEPTH];
    logic [LANE_W-1:0] laneRead;
    logic forward;

    // Lane write a cycle after capture; only masked lanes change
    always_ff @(posedge clk) begin
      if (wrPend_r && wrMask_r[g]) begin
        laneMem[wrAddr_r] <= psb_lane(wrData_r, g);
      end
    end

    // A read of a lane being written sees the new value
    always_comb begin
      forward = wrPend_r && wrMask_r[g] && (wrAddr_r == rdAddr_r);
      laneRead = forward ? psb_lane(wrData_r, g) : laneMem[rdAddr_r];
    end

    // Output register loads when a read was addressed at the last edge
    always_comb begin
      outWord_nxt.parityLines[g] = rdPend_r ? laneRead[LANE_W-1]
        : outWord_r.parityLines[g];
      outWord_nxt.data[g*LANE_DATA_W +: LANE_DATA_W] = rdPend_r
        ? laneRead[LANE_DATA_W-1:0]
        : outWord_r.data[g*LANE_DATA_W +: LANE_DATA_W];
    end
  end

  // Output data register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      outWord_r <= '0;
    end else begin
      outWord_r <= outWord_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  // Drive only valid read data with enable low, outside the masked cycle
  always_comb begin
    dqOutEnable_n = !(drive_r && !oeSync_n && !firstMask_r && !sleepSync);
  end

  assign dqOut = outWord_r;
  assign sleepActive = sleepSync;
  assign deviceSelected = selected_r;
endmodule : psb_sram_ctrl
`default_nettype wire

// ==== verif/psb_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module psb_assertions #(
  parameter int ADDR_W = psb_pkg::ADDR_W_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] addrIn,
  input wire psb_pkg::psb_ctrl_pins_t ctrlPins,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burstOrderInterleave,
  input wire psb_pkg::psb_word_t dqIn,
  input wire psb_pkg::psb_word_t dqOut,
  input wire logic dqOutEnable_n,
  input wire logic sleepActive,
  input wire logic deviceSelected
);
  import psb_pkg::*;
  psb_ctrl_pins_t p;
  logic [2:0] slLow;
  logic ld, on, qs;
  // Load strobe taken, all selects active, sleep long quiet
  assign p = ctrlPins;
  assign ld = (!p.procAddrStrobe_n && !p.chipSelectPrimary_n) || !p.ctrlAddrStrobe_n;
  assign on = !p.chipSelectPrimary_n && p.chipSelectExpandHi && !p.chipSelectExpand_n;
  assign qs = slLow == 3'h7 && !sleepActive;
  // Counts cycles with sleep low, saturating
  always_ff @(posedge clk) begin
    if (!rst_n || sleep_request) begin
      slLow <= 3'h0;
    end else if (slLow != 3'h7) begin
      slLow <= slLow + 3'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_off_hiz:
    assert property (output_enable_n [*5] |-> dqOutEnable_n) else $error("drive, enable off");
  a_sleep_enter:
    assert property (sleep_request [*6] |-> sleepActive) else $error("sleep not entered");
  a_sleep_exit:
    assert property (!sleep_request [*6] |-> !sleepActive) else $error("sleep not left");
  a_sleep_quiet:
    assert property (sleepActive [*2] |-> !deviceSelected && dqOutEnable_n)
      else $error("active in sleep");
  a_load_desel:
    assert property (ld && !on |=> !deviceSelected && dqOutEnable_n) else $error("no deselect");
  a_load_sel:
    assert property (ld && on && qs |=> deviceSelected) else $error("no select");
  a_first_mask:
    assert property (ld && on && !deviceSelected |=> dqOutEnable_n) else $error("first not masked");
  a_drive_sel:
    assert property (!dqOutEnable_n |-> deviceSelected) else $error("drive while deselected");
  a_write_hiz:
    assert property (deviceSelected && p.procAddrStrobe_n && p.ctrlAddrStrobe_n
      && !p.globalWrite_n |=> dqOutEnable_n) else $error("drive in write");
  a_proc_gate:
    assert property (p.ctrlAddrStrobe_n && p.chipSelectPrimary_n && qs |=>
      $stable(deviceSelected)) else $error("gated strobe acted");
endmodule : psb_assertions
bind psb_sram_ctrl psb_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rst_n(rst_n),
  .addrIn(addrIn), .ctrlPins(ctrlPins), .output_enable_n(output_enable_n),
  .sleep_request(sleep_request), .burstOrderInterleave(burstOrderInterleave),
  .dqIn(dqIn), .dqOut(dqOut), .dqOutEnable_n(dqOutEnable_n), .sleepActive(sleepActive),
  .deviceSelected(deviceSelected));
`default_nettype wire

// ==== verif/psb_cpu_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module psb_cpu_model #(
  parameter int ADDR_W = 6
) (
  input wire logic clk,
  input wire psb_pkg::psb_word_t dqOut,
  input wire logic dqOutEnable_n,
  output psb_pkg::psb_ctrl_pins_t pins,
  output logic [ADDR_W-1:0] addr,
  output psb_pkg::psb_word_t dqIn
);
  import psb_pkg::*;
  psb_word_t wrData, junk;
  logic drv;
  // Idle bus until the first cycle
  initial begin
    pins = '1;
    addr = '0;
    wrData = '0;
    drv = 1'b0;
    junk = 36'h5A5A5A5A5;
  end
  // Released lines show a pattern that moves every cycle
  always @(posedge clk) begin
    junk <= {junk[34:0], ~junk[35]};
  end
  assign dqIn = !dqOutEnable_n ? dqOut : drv ? wrData : junk;
  // One bus cycle, launched just after the edge and held to the next
  task automatic go(input psb_ctrl_pins_t p, input logic [ADDR_W-1:0] a, input psb_word_t d,
      input logic en);
    @(posedge clk);
    #1;
    pins = p;
    addr = a;
    wrData = d;
    drv = en;
  endtask : go
endmodule : psb_cpu_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psb_pkg::*;
  localparam int AW = 6;
  localparam logic [2:0] ON = 3'b010;
  localparam logic [1:0] P = 2'b01, C = 2'b10, N = 2'b11;
  localparam logic [2:0] DS [3] = '{3'b000, 3'b011, 3'b110};
  logic clk = 1'b0, rst_n = 1'b0, oeN = 1'b1, sleepReq = 1'b0, strap = 1'b0;
  logic [AW-1:0] addr;
  psb_ctrl_pins_t pins;
  psb_word_t dqIn, dqOut, mem [64];
  logic dqOe_n, slAct, devSel;
  int err_total = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  psb_sram_ctrl #(.ADDR_W(AW)) u_dut (.clk(clk), .rst_n(rst_n), .addrIn(addr),
    .ctrlPins(pins), .output_enable_n(oeN), .sleep_request(sleepReq),
    .burstOrderInterleave(strap), .dqIn(dqIn), .dqOut(dqOut), .dqOutEnable_n(dqOe_n),
    .sleepActive(slAct), .deviceSelected(devSel));
  psb_cpu_model #(.ADDR_W(AW)) u_cpu (.clk(clk), .dqOut(dqOut), .dqOutEnable_n(dqOe_n),
    .pins(pins), .addr(addr), .dqIn(dqIn));
  // Cuts a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish
  task automatic cmpw(input psb_word_t e);
    checks++;
    if (dqOut !== e) begin
      err_total++;
      $display("ERROR %0t read %h exp %h", $time, dqOut, e);
    end
  endtask : cmpw
  task automatic cmpb(input logic g, input logic e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t flag %b exp %b", $time, g, e);
    end
  endtask : cmpb
  // Bus cycle: strobes, advance, {global, byte} write, lanes, {sel1_n, sel2, sel3_n}
  task automatic bus(input logic [1:0] s, input logic v, input logic [1:0] w,
      input logic [3:0] bs, input logic [2:0] cs, input int a, input psb_word_t d);
    u_cpu.go({cs, s, v, w, bs}, a[AW-1:0], d, w != 2'b11);
  endtask : bus
  task automatic rd(input logic [1:0] s, input logic [2:0] cs, input int a);
    bus(s, 1'b1, 2'b11, 4'hF, cs, a, '0);
  endtask : rd
  function automatic psb_word_t rnd();
    logic [63:0] r;
    r = {$urandom, $urandom};
    rnd = r[35:0];
  endfunction : rnd
  // Burst address from the model
  function automatic int bAddr(input int a, input int s);
    bAddr = {a[31:2], strap ? a[1:0] ^ s[1:0] : a[1:0] + s[1:0]};
  endfunction : bAddr
  initial begin
    int b;
    psb_word_t w;
    logic [3:0] bs;
    void'($urandom(32'hA276));
    for (int st = 0; st < 2; st++) begin
      strap = st[0];
      rst_n = 1'b0;
      repeat (4) @(posedge clk);
      #1 rst_n = 1'b1;
      cmpb(dqOe_n, 1'b1);
      cmpb(devSel, 1'b0);
      cmpw('0);
      for (int i = 0; i < 8; i++) begin
        mem[i] = rnd();
        bus(C, 1'b1, 2'b01, 4'hF, ON, i, mem[i]);
      end
      b = 4 + $urandom_range(3);
      for (int j = 0; j < 6; j++) begin
        bus(j == 0 ? P : N, j > 3, 2'b11, 4'hF, ON, j == 0 ? b : $urandom_range(63), '0);
        if (j >= 2) cmpw(mem[bAddr(b, j - 2)]);
      end
    end
    // Processor load ignores write controls; later cycles write
    w = rnd();
    bs = $urandom_range(15);
    bus(P, 1'b0, 2'b00, 4'h0, ON, 5, rnd());
    bus(N, 1'b1, 2'b10, bs, ON, 0, w);
    for (int l = 0; l < 4; l++) begin
      if (!bs[l]) begin
        mem[5].parityLines[l] = w.parityLines[l];
        mem[5].data[l*8 +: 8] = w.data[l*8 +: 8];
      end
    end
    mem[4] = rnd();
    rd(P, ON, 4);
    bus(N, 1'b1, 2'b01, 4'hF, ON, 0, mem[4]);
    bus(2'b00, 1'b1, 2'b01, 4'hF, ON, 6, rnd());
    oeN = 1'b0;
    for (int i = 0; i < 10; i++) begin
      rd(i >= 8 ? N : i[0] ? C : P, ON, i);
      if (i >= 2) cmpw(mem[i - 2]);
    end
    cmpb(dqOe_n, 1'b0);
    // Deselect by each inactive select, then reselect
    foreach (DS[k]) begin
      rd(C, DS[k], 0);
      rd(P, 3'b110, 1);
      cmpb(devSel, 1'b0);
      cmpb(dqOe_n, 1'b1);
      rd(N, ON, 1);
      cmpb(devSel, 1'b0);
      rd(P, ON, 3);
      rd(N, ON, 3);
      cmpb(dqOe_n, 1'b1);
      rd(N, ON, 0);
      cmpw(mem[3]);
      cmpb(devSel, 1'b1);
    end
    oeN = 1'b1;
    repeat (6) rd(N, ON, 0);
    cmpb(dqOe_n, 1'b1);
    sleepReq = 1'b1;
    repeat (8) rd(P, ON, 0);
    cmpb(slAct, 1'b1);
    cmpb(devSel, 1'b0);
    sleepReq = 1'b0;
    repeat (8) rd(N, ON, 0);
    cmpb(slAct, 1'b0);
    rd(P, ON, 2);
    rd(N, ON, 0);
    rd(N, ON, 0);
    cmpw(mem[2]);
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
